// file: rtl/meas_delay_params.svh
// Register offsets, field positions, reset values and timing counts
`ifndef MEAS_DELAY_PARAMS_SVH
`define MEAS_DELAY_PARAMS_SVH
`define MFD_OFFSET 8'h3B
`define CID_OFFSET 8'h3F
`define MFD_ADDR 12'h0EC
`define CID_ADDR 12'h0FC
`define MFD_PHASE_BIT 7
`define MFD_AMP_BIT 6
`define MFD_DEL_MSB 3
`define MFD_RESET 8'h00
`define MFD_WMASK 8'hCF
`define TANA_PROBE 4'h7
`define CLK_MHZ 40
`define TENTH_MS_NS 100000
`define TENTH_MS_CYC ((`TENTH_MS_NS * `CLK_MHZ) / 1000)
`endif

// file: rtl/meas_delay_pkg.sv
// Types shared by the measurement delay block
package meas_delay_pkg;
  typedef enum logic [1:0] {
    ROUTE_NONE,
    ROUTE_AMP_T2,
    ROUTE_PHASE_T2,
    ROUTE_BOTH
  } probe_route_t;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PROLONG,
    ST_MEASURE
  } wake_state_t;
endpackage : meas_delay_pkg

// file: rtl/prolong_table_if.sv
// Lookup request and answer between top and prolongation table
`timescale 1ns/1ps
interface prolong_table_if;
  logic wake_range;
  logic [2:0] wake_period;
  logic [3:0] setting;
  logic [7:0] tenths;
  modport user (output wake_range, output wake_period, output setting, input tenths);
  modport table_side (input wake_range, input wake_period, input setting, output tenths);
endinterface : prolong_table_if

// file: rtl/prolong_table.sv
// Wake-up pulse prolongation lookup in tenths of a millisecond
`timescale 1ns/1ps
module prolong_table (
  prolong_table_if.table_side lk
);
  logic [7:0] row [0:15][0:15];
  always_comb begin
    row[0] = '{8'h00, 8'h07, 8'h0D, 8'h13, 8'h19, 8'h1F, 8'h25, 8'h2B,
      8'h31, 8'h37, 8'h3D, 8'h49, 8'h55, 8'h61, 8'h6D, 8'h7A};
    row[1] = '{8'h00, 8'h04, 8'h0A, 8'h10, 8'h17, 8'h1D, 8'h23, 8'h29,
      8'h2F, 8'h35, 8'h3B, 8'h47, 8'h53, 8'h5F, 8'h6B, 8'h77};
    row[2] = '{8'h00, 8'h00, 8'h08, 8'h0E, 8'h14, 8'h1A, 8'h20, 8'h26,
      8'h2C, 8'h32, 8'h38, 8'h44, 8'h51, 8'h5D, 8'h69, 8'h75};
    row[3] = '{8'h00, 8'h00, 8'h06, 8'h0C, 8'h12, 8'h18, 8'h1E, 8'h24,
      8'h2A, 8'h30, 8'h36, 8'h42, 8'h4E, 8'h5A, 8'h66, 8'h72};
    row[4] = '{8'h00, 8'h00, 8'h00, 8'h09, 8'h0F, 8'h15, 8'h1C, 8'h22,
      8'h28, 8'h2E, 8'h34, 8'h40, 8'h4C, 8'h58, 8'h64, 8'h70};
    row[5] = '{8'h00, 8'h00, 8'h00, 8'h07, 8'h0D, 8'h13, 8'h19, 8'h1F,
      8'h25, 8'h2B, 8'h31, 8'h3D, 8'h49, 8'h56, 8'h62, 8'h6E};
    row[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0B, 8'h11, 8'h17, 8'h1D,
      8'h23, 8'h29, 8'h32, 8'h3B, 8'h47, 8'h53, 8'h5F, 8'h6B};
    row[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h0E, 8'h27, 8'h1A,
      8'h21, 8'h27, 8'h2D, 8'h39, 8'h45, 8'h51, 8'h5D, 8'h69};
    row[8] = '{8'h00, 8'h09, 8'h0F, 8'h15, 8'h1B, 8'h21, 8'h27, 8'h2D,
      8'h33, 8'h39, 8'h3F, 8'h4B, 8'h57, 8'h63, 8'h70, 8'h7C};
    row[9] = '{8'h00, 8'h09, 8'h0F, 8'h15, 8'h1B, 8'h21, 8'h27, 8'h2D,
      8'h33, 8'h39, 8'h3F, 8'h4B, 8'h57, 8'h63, 8'h6F, 8'h7B};
    row[10] = '{8'h00, 8'h08, 8'h0E, 8'h14, 8'h1B, 8'h21, 8'h27, 8'h2D,
      8'h33, 8'h39, 8'h3F, 8'h4B, 8'h57, 8'h63, 8'h6F, 8'h7B};
    row[11] = '{8'h00, 8'h08, 8'h0E, 8'h14, 8'h1A, 8'h20, 8'h26, 8'h2C,
      8'h32, 8'h38, 8'h3F, 8'h4B, 8'h57, 8'h63, 8'h6F, 8'h7B};
    row[12] = '{8'h00, 8'h08, 8'h0E, 8'h14, 8'h1A, 8'h20, 8'h26, 8'h2C,
      8'h32, 8'h38, 8'h3E, 8'h4A, 8'h56, 8'h63, 8'h6F, 8'h7B};
    row[13] = '{8'h00, 8'h08, 8'h0E, 8'h14, 8'h1A, 8'h20, 8'h26, 8'h2C,
      8'h32, 8'h38, 8'h3E, 8'h4A, 8'h56, 8'h62, 8'h6E, 8'h7A};
    row[14] = '{8'h00, 8'h08, 8'h0E, 8'h14, 8'h1A, 8'h20, 8'h26, 8'h2C,
      8'h32, 8'h38, 8'h3E, 8'h4A, 8'h56, 8'h62, 8'h6E, 8'h7A};
    row[15] = '{8'h00, 8'h07, 8'h0D, 8'h13, 8'h19, 8'h1F, 8'h25, 8'h2B,
      8'h32, 8'h38, 8'h3E, 8'h4A, 8'h56, 8'h62, 8'h6E, 8'h7A};
  end
  // Row picked by range and period, column by setting
  assign lk.tenths = row[{lk.wake_range, lk.wake_period}][lk.setting];
endmodule : prolong_table

// file: rtl/meas_delay_regs.sv
// Measurement field delay and chip identity registers on APB
//
// Contract
// - Two route bits form one select: none, amp to pin2, phase to pin2, amp to pin1 with phase to pin2.
// - Either route bit set switches the transmit field on.
// - Prolongation field zero adds nothing; nonzero adds a table delay.
// - Prolongation runs before field enable and before the measurement.
// - Prolongation length depends on wake-up range bit and period select.
// - Read-only identity byte: five bit type code, three bit revision.
`timescale 1ns/1ps
`include "meas_delay_params.svh"
module meas_delay_regs #(
  parameter logic [4:0] PART_TYPE = 5'h0A,
  parameter logic [2:0] SILICON_REV = 3'h5,
  parameter int TENTH_CYCLES = `TENTH_MS_CYC
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Wake-up timer settings and events
  input wire logic wake_range_i,
  input wire logic [2:0] wake_period_i,
  input wire logic wake_pulse_i,
  // Analog test routing and field
  output meas_delay_pkg::probe_route_t probe_route_o,
  output logic amp_to_test_pin_one_o,
  output logic amp_to_test_pin_two_o,
  output logic phase_to_test_pin_two_o,
  output logic field_on_o,
  output logic measure_start_o,
  output logic prolong_busy_o
);
  import meas_delay_pkg::*;

  // Register state and APB decode
  logic [7:0] mfd_q;
  logic [7:0] mfd_d;
  logic [31:0] rdata_d;
  logic apb_write;
  logic apb_read;
  logic hit_mfd;
  logic hit_cid;
  logic field_req;
  probe_route_t route;

  // Timer domain inputs
  logic [4:0] async_in;
  logic [4:0] synced;
  logic wake_level;
  logic wake_prev_q;
  logic wake_rise;
  logic wake_range_s;
  logic [2:0] wake_period_s;
  logic [3:0] set_prev_q;
  logic [3:0] set_held_q;

  // Prolongation sequencer
  logic [31:0] tick_q;
  logic tenth_tick;
  logic [7:0] left_q;
  wake_state_t state_q;
  wake_state_t state_d;
  prolong_table_if lk ();

  prolong_table u_table (
    .lk(lk.table_side)
  );

  // APB decode; every transfer completes without wait states
  assign apb_write = psel && penable && pwrite;
  assign apb_read = psel && !pwrite;
  assign pready = 1'b1;
  always_comb begin
    hit_mfd = 1'b0;
    hit_cid = 1'b0;
    case (paddr)
      `MFD_ADDR: begin
        hit_mfd = 1'b1;
      end
      `CID_ADDR: begin
        hit_cid = 1'b1;
      end
      default: begin
      end
    endcase
  end
  // Unmapped address or identity write refused
  assign pslverr = psel && penable && !(hit_mfd || (hit_cid && !pwrite));

  // Read word of the addressed register
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit_mfd) begin
      rdata_d = {24'h00_0000, mfd_q};
    end else if (hit_cid) begin
      rdata_d = {24'h00_0000, PART_TYPE, SILICON_REV};
    end
  end

  // Reserved bits masked off on write
  always_comb begin
    mfd_d = mfd_q;
    if (pstrb[0]) begin
      mfd_d = pwdata[7:0] & `MFD_WMASK;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mfd_q <= `MFD_RESET;
    end else if (apb_write && hit_mfd) begin
      mfd_q <= mfd_d;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prdata <= 32'h0000_0000;
    end else if (apb_read && !penable) begin
      prdata <= rdata_d;
    end
  end

  // Route select decode
  assign route = probe_route_t'({mfd_q[`MFD_PHASE_BIT], mfd_q[`MFD_AMP_BIT]});
  assign probe_route_o = route;
  always_comb begin
    amp_to_test_pin_one_o = 1'b0;
    amp_to_test_pin_two_o = 1'b0;
    phase_to_test_pin_two_o = 1'b0;
    case (route)
      ROUTE_NONE: begin
      end
      ROUTE_AMP_T2: begin
        amp_to_test_pin_two_o = 1'b1;
      end
      ROUTE_PHASE_T2: begin
        phase_to_test_pin_two_o = 1'b1;
      end
      ROUTE_BOTH: begin
        amp_to_test_pin_one_o = 1'b1;
        phase_to_test_pin_two_o = 1'b1;
      end
      default: begin
      end
    endcase
  end

  // Two-flop synchronisers for the timer domain inputs
  assign async_in = {wake_pulse_i, wake_range_i, wake_period_i};
  for (genvar b = 0; b < 5; b++) begin : g_sync
    logic s1_q;
    logic s2_q;
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
      end else begin
        s1_q <= async_in[b];
        s2_q <= s1_q;
      end
    end
    assign synced[b] = s2_q;
  end
  assign wake_level = synced[4];
  assign wake_range_s = synced[3];
  assign wake_period_s = synced[2:0];

  // Edge detector idles low like the pin: no false edge after reset
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wake_prev_q <= 1'b0;
    end else begin
      wake_prev_q <= wake_level;
    end
  end
  assign wake_rise = wake_level && !wake_prev_q;

  // Multi-bit settings used only once two synced samples agree
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      set_prev_q <= 4'h0;
      set_held_q <= 4'h0;
    end else begin
      set_prev_q <= {wake_range_s, wake_period_s};
      if ({wake_range_s, wake_period_s} == set_prev_q) begin
        set_held_q <= set_prev_q;
      end
    end
  end

  // Table lookup from timer settings and the delay field
  assign lk.wake_range = set_held_q[3];
  assign lk.wake_period = set_held_q[2:0];
  assign lk.setting = mfd_q[`MFD_DEL_MSB:0];

  // Tenth-millisecond enable pulse; divider runs only while prolonging
  assign tenth_tick = (state_q == ST_PROLONG) && (tick_q == 32'(TENTH_CYCLES - 1));
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick_q <= 32'h0000_0000;
    end else if ((state_q != ST_PROLONG) || tenth_tick) begin
      tick_q <= 32'h0000_0000;
    end else begin
      tick_q <= tick_q + 32'h0000_0001;
    end
  end

  // Tenths still to wait, loaded at the wake edge
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      left_q <= 8'h00;
    end else if ((state_q == ST_IDLE) && wake_rise) begin
      left_q <= lk.tenths;
    end else if (tenth_tick) begin
      left_q <= left_q - 8'h01;
    end
  end

  // Prolongation sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (wake_rise) begin
          if (lk.tenths == 8'h00) begin
            state_d = ST_MEASURE;
          end else begin
            state_d = ST_PROLONG;
          end
        end
      end
      ST_PROLONG: begin
        if (tenth_tick && (left_q == 8'h01)) begin
          state_d = ST_MEASURE;
        end
      end
      ST_MEASURE: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign prolong_busy_o = (state_q == ST_PROLONG);
  assign measure_start_o = (state_q == ST_MEASURE);
  assign field_req = mfd_q[`MFD_PHASE_BIT] || mfd_q[`MFD_AMP_BIT];
  // Field held off while prolongation runs
  assign field_on_o = field_req && (state_q != ST_PROLONG);
endmodule : meas_delay_regs

// file: verif/meas_delay_assertions.sv
// Concurrent checks on the measurement delay register block ports
`timescale 1ns/1ps
`include "meas_delay_params.svh"
module meas_delay_checker
  import meas_delay_pkg::*;
#(
  parameter logic [4:0] PART_TYPE = 5'h0A,
  parameter logic [2:0] SILICON_REV = 3'h5
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire meas_delay_pkg::probe_route_t probe_route_o,
  input wire logic amp_to_test_pin_one_o,
  input wire logic amp_to_test_pin_two_o,
  input wire logic phase_to_test_pin_two_o,
  input wire logic field_on_o,
  input wire logic measure_start_o,
  input wire logic prolong_busy_o
);
  wire acc = psel && penable;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  property p_pin_one; amp_to_test_pin_one_o == (probe_route_o == ROUTE_BOTH); endproperty
  a_pin_one: assert property (p_pin_one) else $error("pin one route wrong");
  property p_amp_two; amp_to_test_pin_two_o == (probe_route_o == ROUTE_AMP_T2); endproperty
  a_amp_two: assert property (p_amp_two) else $error("amp pin two route wrong");
  property p_phase_two; phase_to_test_pin_two_o == probe_route_o[1]; endproperty
  a_phase_two: assert property (p_phase_two) else $error("phase route wrong");
  property p_field; field_on_o == (probe_route_o != ROUTE_NONE && !prolong_busy_o); endproperty
  a_field: assert property (p_field) else $error("field state wrong");
  property p_hold; !(acc && pwrite && paddr == `MFD_ADDR) |=> $stable(probe_route_o); endproperty
  a_hold: assert property (p_hold) else $error("route changed without write");
  property p_pulse; measure_start_o |-> !prolong_busy_o ##1 !measure_start_o; endproperty
  a_pulse: assert property (p_pulse) else $error("measure pulse wrong");
  property p_busy; $rose(prolong_busy_o) |-> prolong_busy_o [*8]; endproperty
  a_busy: assert property (p_busy) else $error("prolongation too short");
  property p_id; acc && !pwrite && paddr == `CID_ADDR |-> prdata == {24'h0, PART_TYPE, SILICON_REV};
  endproperty
  a_id: assert property (p_id) else $error("identity read wrong");
  property p_id_wr; acc && pwrite && paddr == `CID_ADDR |-> pslverr; endproperty
  a_id_wr: assert property (p_id_wr) else $error("identity write accepted");
  property p_rsvd; acc && !pwrite && paddr == `MFD_ADDR |-> prdata[31:4] == {24'h0, probe_route_o, 2'b00};
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("delay reg read wrong");
endmodule : meas_delay_checker

bind meas_delay_regs meas_delay_checker #(.PART_TYPE(PART_TYPE), .SILICON_REV(SILICON_REV)) u_chk (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .probe_route_o(probe_route_o),
  .amp_to_test_pin_one_o(amp_to_test_pin_one_o), .amp_to_test_pin_two_o(amp_to_test_pin_two_o),
  .phase_to_test_pin_two_o(phase_to_test_pin_two_o), .field_on_o(field_on_o),
  .measure_start_o(measure_start_o), .prolong_busy_o(prolong_busy_o)
);

// file: verif/meas_delay_regs_tb.sv
// Self-checking bench for the measurement delay register block
`timescale 1ns/1ps
`include "meas_delay_params.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fails++; \
  $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module meas_delay_regs_tb;
  import meas_delay_pkg::*;
  localparam logic [4:0] PT = 5'h0A; // Arbitrary code
  localparam logic [2:0] RV = 3'h5; // Arbitrary code
  logic mclk_i = 1'b0, reset_n_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic wake_range_i = 1'b0, wake_pulse_i = 1'b0, pready, pslverr, err;
  logic pin1, pin2a, pin2p, field, mstart, busy;
  logic [2:0] wake_period_i = 3'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  probe_route_t route;
  int fails = 0, compares = 0, n;
  int cases[8][4] = '{'{0, 0, 1, 7}, '{0, 0, 15, 122}, '{0, 1, 1, 4}, '{0, 2, 2, 8},
    '{0, 7, 6, 39}, '{1, 0, 15, 124}, '{1, 7, 1, 7}, '{0, 0, 0, 0}};
  meas_delay_regs #(.PART_TYPE(PT), .SILICON_REV(RV), .TENTH_CYCLES(4)) i_dut (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wake_range_i(wake_range_i), .wake_period_i(wake_period_i),
    .wake_pulse_i(wake_pulse_i), .probe_route_o(route), .amp_to_test_pin_one_o(pin1),
    .amp_to_test_pin_two_o(pin2a), .phase_to_test_pin_two_o(pin2p), .field_on_o(field),
    .measure_start_o(mstart), .prolong_busy_o(busy)
  );
  initial begin
    forever #12.5 mclk_i = ~mclk_i;
  end
  task report_and_stop;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wake(input logic rg, input logic [2:0] pd, input logic [3:0] s, input int ex);
    int k;
    apb(1'b1, `MFD_ADDR, {24'h0, 4'h4, s});
    wake_range_i <= rg;
    wake_period_i <= pd;
    repeat (4) @(posedge mclk_i);
    wake_pulse_i <= 1'b1;
    k = 0;
    n = 0;
    while (mstart !== 1'b1 && n < 2000) begin
      @(negedge mclk_i);
      n++;
      if (busy === 1'b1) k++;
    end
    if (n >= 2000) begin
      fails++;
      report_and_stop();
    end
    `CHK("busy cycles", ex, k)
    @(posedge mclk_i);
    wake_pulse_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    `CHK("field after", 1'b1, field)
  endtask : wake
  initial begin
    repeat (12) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    apb(1'b0, `MFD_ADDR, 32'h0);
    `CHK("delay reset", 32'h0, rd)
    apb(1'b0, `CID_ADDR, 32'h0);
    `CHK("identity", {24'h0, PT, RV}, rd)
    apb(1'b1, `CID_ADDR, 32'hFF);
    `CHK("id write err", 1'b1, err)
    apb(1'b0, `CID_ADDR, 32'h0);
    `CHK("identity kept", {24'h0, PT, RV}, rd)
    apb(1'b1, `MFD_ADDR, 32'hFFFFFFFF);
    `CHK("write err", 1'b0, err)
    apb(1'b0, `MFD_ADDR, 32'h0);
    `CHK("reserved zero", 32'hCF, rd)
    apb(1'b0, 12'h0F0, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, `MFD_ADDR, 32'(r) << 6);
      @(negedge mclk_i);
      `CHK("route", 2'(r), route)
      `CHK("pin1", r == 3, pin1)
      `CHK("pin2 amp", r == 1, pin2a)
      `CHK("pin2 phase", r >= 2, pin2p)
      `CHK("field", r != 0, field)
    end
    for (int i = 0; i < 8; i++) begin
      wake(cases[i][0][0], 3'(cases[i][1]), 4'(cases[i][2]), cases[i][3] * 4);
    end
    report_and_stop();
  end
endmodule : meas_delay_regs_tb
